// File: logic/aafx_pkg.sv
// What this block does
// [R01] Keep trailing ancillary bytes of each frame for the host, at most 54.
// [R02] In checked mode, check bytes found now serve the following frame.
// [R03] In checked mode, the last 2 frame bytes are the fixed program bytes.
// [R04] Fixed program bytes of every frame go into the host buffer.
// [R05] Byte before the fixed program bytes checks sub-bands 0 to 3.
// [R06] Byte before that checks sub-bands 4 to 7.
// [R07] Sub-band limit above 8 adds a check byte for bands 8 to 15.
// [R08] Sub-band limit above 16 adds a check byte for bands 16 to 31.
// [R09] Bytes ahead of the check bytes are extended program bytes, at most 52.
// [R10] Producer should avoid ending unaligned layer I frames with a one bit.
// [R11] Producer encodes a varying ancillary length inside the fixed program bytes.
// [R12] Host reads bytes newest first: last captured byte comes out first.
// [R13] Checked mode delivers 2 fixed program bytes, then up to 52 extended.
// [R14] Buffer reloads per frame, valid only while frame lock flag is set.
// [R15] Check bytes are held internally and kept out of host program data.
package aafx_pkg;
  localparam int BYTE_W = 8;
  localparam int TOK_W = BYTE_W + 1;
  localparam int CNT_W = 6;
  localparam int ANC_MAX = 54;
  localparam int FIXED_PROGRAM_BYTES_LEN = 2;
  localparam int EXTENDED_PROGRAM_BYTES_MAX = 52;
  localparam int CHECK_MAX = 4;
  localparam int STAGE_DEPTH = ANC_MAX + CHECK_MAX;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CNT_W-1:0] ANC_MAX_C = 6'h36;
  localparam logic [CNT_W-1:0] FIXED_PROGRAM_BYTES_LEN_C = 6'h02;
  localparam logic [CNT_W-1:0] EXTENDED_PROGRAM_BYTES_MAX_C = 6'h34;
  localparam logic [CNT_W-1:0] STAGE_DEPTH_C = 6'h3A;
  localparam logic [CNT_W-1:0] CHECK_BASE_C = 6'h02;
  localparam logic [5:0] LIMIT_BAND_2 = 6'h08;
  localparam logic [5:0] LIMIT_BAND_3 = 6'h10;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

  // Number of check bytes carried for a given sub-band limit
  function automatic logic [CNT_W-1:0] check_len(input logic [5:0] limit);
    logic [CNT_W-1:0] n;
    n = CHECK_BASE_C;
    if (limit > LIMIT_BAND_2)
      n = n + 6'h01;
    if (limit > LIMIT_BAND_3)
      n = n + 6'h01;
    return n;
  endfunction

  function automatic logic [CNT_W-1:0] min_cnt(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    return (a < b) ? a : b;
  endfunction
endpackage

// File: logic/aafx_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aafx_byte_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: logic/aafx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module aafx_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  aafx_byte_if.snk wr,
  aafx_byte_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;

  wire do_wr = wr.valid & wr.ready;
  wire do_rd = rd.valid & rd.ready;
  wire [AW-1:0] wp_nx = (wp_q == LAST_C) ? '0 : wp_q + 1'b1;
  wire [AW-1:0] rp_nx = (rp_q == LAST_C) ? '0 : rp_q + 1'b1;

  assign wr.ready = (cnt_q != DEPTH_C);
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rp_q];

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_wr)
        wp_q <= wp_nx;
      if (do_rd)
        rp_q <= rp_nx;
      if (do_wr && !do_rd)
        cnt_q <= cnt_q + 1'b1;
      else if (do_rd && !do_wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge ref_clk_i)
  begin
    if (do_wr)
      mem_q[wp_q] <= wr.data;
  end
endmodule
`default_nettype wire

// File: logic/aafx_extractor.sv
`timescale 1ns/1ps
`default_nettype none
module aafx_extractor
  import aafx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  input wire logic [BYTE_W-1:0] in_data_i,
  input wire logic in_last_i,
  output logic in_ready_o,
  input wire logic check_enable_i,
  input wire logic [5:0] subband_limit_i,
  input wire logic frame_locked_flag_i,
  input wire logic rd_req_i,
  input wire logic rd_restart_i,
  output logic [BYTE_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic [CNT_W-1:0] rd_count_o,
  output logic buf_valid_o,
  output logic frame_done_o,
  output logic [BYTE_W-1:0] check_byte_bands_0_3_o,
  output logic [BYTE_W-1:0] check_byte_bands_4_7_o,
  output logic [BYTE_W-1:0] check_byte_bands_8_15_o,
  output logic [BYTE_W-1:0] check_byte_bands_16_31_o,
  output logic [2:0] check_count_o,
  output logic check_valid_o
);
  aafx_byte_if #(.W(TOK_W)) fin ();
  aafx_byte_if #(.W(TOK_W)) fout ();

  assign fin.valid = in_valid_i;
  assign fin.data = {in_last_i, in_data_i};
  assign in_ready_o = fin.ready;

  aafx_fifo #(.W(TOK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .wr(fin),
    .rd(fout)
  );

  // Stage index 0 is always the newest byte of the frame
  logic [BYTE_W-1:0] stage_q [STAGE_DEPTH];
  logic [CNT_W-1:0] cnt_q;
  logic done_q;
  logic [BYTE_W-1:0] host_q [ANC_MAX];
  logic [CNT_W-1:0] host_cnt_q;
  logic [CNT_W-1:0] rd_ptr_q;
  logic [BYTE_W-1:0] rd_data_q;
  logic rd_valid_q;
  logic loaded_q;
  logic [BYTE_W-1:0] chk_q [CHECK_MAX];
  logic [2:0] chk_n_q;
  logic chk_valid_q;

  // Drain stalls for the snapshot cycle so the stage is stable while copied
  assign fout.ready = ~done_q;
  wire take = fout.valid & fout.ready;
  wire take_last = take & fout.data[BYTE_W];

  wire [CNT_W-1:0] n_chk = check_len(subband_limit_i);
  wire [CNT_W-1:0] fixed_plus = FIXED_PROGRAM_BYTES_LEN_C + n_chk;
  wire [CNT_W-1:0] extended_program_bytes_raw = (cnt_q > fixed_plus) ? cnt_q - fixed_plus : CNT_RST;
  wire [CNT_W-1:0] extended_program_bytes_n = min_cnt(extended_program_bytes_raw, EXTENDED_PROGRAM_BYTES_MAX_C);
  wire [CNT_W-1:0] fixed_program_bytes_n = min_cnt(cnt_q, FIXED_PROGRAM_BYTES_LEN_C);
  wire [CNT_W-1:0] plain_n = min_cnt(cnt_q, ANC_MAX_C);
  wire [CNT_W-1:0] snap_n = check_enable_i ? fixed_program_bytes_n + extended_program_bytes_n : plain_n;
  wire snap_chk_ok = check_enable_i & (cnt_q >= fixed_plus);
  wire rd_ok = rd_req_i & ~done_q & ~rd_restart_i & (rd_ptr_q < host_cnt_q);

  // Optional check bytes read as zero when the limit leaves them out
  wire [BYTE_W-1:0] chk_bands_8_15_nx = (n_chk > 6'h02) ? stage_q[4] : BYTE_RST;
  wire [BYTE_W-1:0] chk_bands_16_31_nx = (n_chk > 6'h03) ? stage_q[5] : BYTE_RST;
  wire [2:0] chk_n_nx = check_enable_i ? n_chk[2:0] : 3'h0;

  // Host slot k: fixed bytes stay put, extended bytes skip the check bytes
  function automatic int host_src(input int k, input logic chk,
                                  input logic [CNT_W-1:0] n);
    if (chk && k >= FIXED_PROGRAM_BYTES_LEN)
      return k + int'(n);
    return k;
  endfunction

  // Reload source per host slot, worked out beside the flops
  logic [BYTE_W-1:0] host_nx [ANC_MAX];
  for (genvar k = 0; k < ANC_MAX; k++)
  begin : g_slot
    assign host_nx[k] = stage_q[host_src(k, check_enable_i, n_chk)];
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= CNT_RST;
    end
    else if (done_q)
      cnt_q <= CNT_RST; // R14
    else if (take && cnt_q != STAGE_DEPTH_C)
      cnt_q <= cnt_q + 6'h01; // R01
  end

  // One-cycle reload pulse after the frame's last byte leaves the FIFO
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      done_q <= 1'b0;
    else
      done_q <= take_last;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (take)
    begin
      stage_q[0] <= fout.data[BYTE_W-1:0]; // R12
      for (int i = 1; i < STAGE_DEPTH; i++)
        stage_q[i] <= stage_q[i-1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int k = 0; k < ANC_MAX; k++)
        host_q[k] <= BYTE_RST;
    end
    else if (done_q)
    begin
      for (int k = 0; k < ANC_MAX; k++)
        host_q[k] <= host_nx[k]; // R03 R04 R09 R13 R15
    end
  end

  // Count and loaded flag move with the slots so a reader never sees a mix
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      host_cnt_q <= CNT_RST;
      loaded_q <= 1'b0;
    end
    else if (done_q)
    begin
      host_cnt_q <= snap_n; // R01 R09 R13
      loaded_q <= 1'b1; // R14
    end
  end

  // Check bytes latched now are consumed while the next frame decodes
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int c = 0; c < CHECK_MAX; c++)
        chk_q[c] <= BYTE_RST;
    end
    else if (done_q)
    begin
      chk_q[0] <= stage_q[2]; // R05 R02
      chk_q[1] <= stage_q[3]; // R06
      chk_q[2] <= chk_bands_8_15_nx; // R07
      chk_q[3] <= chk_bands_16_31_nx; // R08
    end
  end

  // Count and valid tell the next frame's check how many bytes to trust
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      chk_n_q <= 3'h0;
      chk_valid_q <= 1'b0;
    end
    else if (done_q)
    begin
      chk_n_q <= chk_n_nx; // R15
      chk_valid_q <= snap_chk_ok; // R02
    end
  end

  // A reload outranks a host read in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_ptr_q <= CNT_RST;
    end
    else if (done_q || rd_restart_i)
      rd_ptr_q <= CNT_RST;
    else if (rd_ok)
      rd_ptr_q <= rd_ptr_q + 6'h01;
  end

  // Read data holds until the next accepted read
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_q <= BYTE_RST;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_ok;
      if (rd_ok)
        rd_data_q <= host_q[rd_ptr_q]; // R12
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_count_o = host_cnt_q;
  assign buf_valid_o = loaded_q & frame_locked_flag_i; // R14
  assign frame_done_o = done_q;
  assign check_byte_bands_0_3_o = chk_q[0];
  assign check_byte_bands_4_7_o = chk_q[1];
  assign check_byte_bands_8_15_o = chk_q[2];
  assign check_byte_bands_16_31_o = chk_q[3];
  assign check_count_o = chk_n_q;
  assign check_valid_o = chk_valid_q;
endmodule
`default_nettype wire

// File: verif/aafx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module aafx_checker
  import aafx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic check_enable_i,
  input wire logic [5:0] subband_limit_i,
  input wire logic frame_locked_flag_i,
  input wire logic rd_req_i,
  input wire logic rd_valid_o,
  input wire logic [CNT_W-1:0] rd_count_o,
  input wire logic buf_valid_o,
  input wire logic frame_done_o,
  input wire logic [2:0] check_count_o,
  input wire logic check_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence snap_chk;
    frame_done_o && check_enable_i;
  endsequence
  read_answer_a: assert property (rd_valid_o |-> $past(rd_req_i))
    else $error("read data without request");
  done_pulse_a: assert property (frame_done_o |=> !frame_done_o && !rd_valid_o)
    else $error("reload pulse too long");
  count_limit_a: assert property (rd_count_o <= ANC_MAX_C)
    else $error("buffer count too big");
  read_count_a: assert property (rd_valid_o |-> rd_count_o != 6'h00)
    else $error("read from empty buffer");
  lock_gate_a: assert property (buf_valid_o |-> frame_locked_flag_i)
    else $error("buffer valid without lock");
  plain_nochk_a: assert property (frame_done_o && !check_enable_i |=>
    check_count_o == 3'h0 && !check_valid_o)
    else $error("check bytes in plain mode");
  two_chk_a: assert property ((snap_chk and subband_limit_i <= 6'h08) ##1
    check_valid_o |-> check_count_o == 3'h2)
    else $error("wrong count at low limit");
  three_chk_a: assert property ((snap_chk and subband_limit_i > 6'h08
    && subband_limit_i <= 6'h10) ##1 check_valid_o |-> check_count_o == 3'h3)
    else $error("wrong count at mid limit");
  four_chk_a: assert property ((snap_chk and subband_limit_i > 6'h10) ##1
    check_valid_o |-> check_count_o == 3'h4)
    else $error("wrong count at high limit");
  reload_lock_a: assert property (frame_done_o && frame_locked_flag_i ##1
    frame_locked_flag_i |-> buf_valid_o)
    else $error("buffer not valid after reload");
endmodule
bind aafx_extractor aafx_checker chk (
  .ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i),
  .check_enable_i(check_enable_i),
  .subband_limit_i(subband_limit_i),
  .frame_locked_flag_i(frame_locked_flag_i),
  .rd_req_i(rd_req_i),
  .rd_valid_o(rd_valid_o),
  .rd_count_o(rd_count_o),
  .buf_valid_o(buf_valid_o),
  .frame_done_o(frame_done_o),
  .check_count_o(check_count_o),
  .check_valid_o(check_valid_o)
);
`default_nettype wire

// File: verif/aafx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module aafx_host_model
  import aafx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rd_valid_i,
  input wire logic [BYTE_W-1:0] rd_data_i,
  output logic rd_req_o
);
  initial rd_req_o = 1'b0;
  // Gap models a slow host between reads
  task automatic read_byte(input int gap, output logic [7:0] b, output logic got);
    int i;
    repeat (gap) @(negedge ref_clk_i);
    rd_req_o = 1'b1;
    @(negedge ref_clk_i);
    rd_req_o = 1'b0;
    got = 1'b0;
    b = 8'h00;
    for (i = 0; i < 3 && !got; i++)
    begin
      got = rd_valid_i;
      b = rd_data_i;
      @(negedge ref_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// File: verif/tb_audio_frame_ancillary_extractor.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("[ERR] %0t got %h exp %h", $time, a, b); \
    end \
  end
module tb_audio_frame_ancillary_extractor
  import aafx_pkg::*;
;
  logic ref_clk_i = 0, rst_b_i = 0, in_valid_i = 0, in_last_i = 0;
  logic check_enable_i = 0, frame_locked_flag_i = 0, rd_restart_i = 0;
  logic [7:0] in_data_i = 8'h00;
  logic [5:0] subband_limit_i = 6'h00;
  wire logic rd_req_i;
  wire logic in_ready_o, rd_valid_o, buf_valid_o, frame_done_o, check_valid_o;
  wire logic [7:0] rd_data_o, check_byte_bands_0_3_o, check_byte_bands_4_7_o;
  wire logic [7:0] check_byte_bands_8_15_o, check_byte_bands_16_31_o;
  wire logic [5:0] rd_count_o;
  wire logic [2:0] check_count_o;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] b;
  logic g;
  always #20 ref_clk_i = ~ref_clk_i;
  aafx_extractor dut (.*);
  aafx_host_model host (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid_o),
    .rd_data_i(rd_data_o), .rd_req_o(rd_req_i));
  // Byte j of a frame is 10h + j; frames stay byte aligned
  task automatic send(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(negedge ref_clk_i);
      in_valid_i = 1'b1;
      in_data_i = 8'h10 + i[7:0];
      in_last_i = (i == n - 1);
      while (!in_ready_o) @(negedge ref_clk_i);
    end
    @(negedge ref_clk_i);
    in_valid_i = 1'b0;
    for (i = 0; i < 100 && !frame_done_o; i++) @(negedge ref_clk_i);
    `CHK(frame_done_o, 1'b1)
    @(negedge ref_clk_i);
  endtask
  task automatic plain_frame;
    int k;
    check_enable_i = 1'b0;
    send(60);
    `CHK(rd_count_o, 6'h36)
    for (k = 0; k < 54; k++)
    begin
      host.read_byte(k % 3, b, g);
      `CHK({g, b}, {1'b1, 8'(8'h4B - k)})
    end
    host.read_byte(0, b, g);
    `CHK(g, 1'b0)
    $display("plain frame done");
  endtask
  task automatic checked_frames;
    int t, k, n;
    logic [5:0] lims [4] = '{6'h08, 6'h09, 6'h10, 6'h14};
    check_enable_i = 1'b1;
    for (t = 0; t < 4; t++)
    begin
      subband_limit_i = lims[t];
      n = 2 + (t > 0) + (t > 2);
      send(60);
      `CHK(check_count_o, 3'(n))
      `CHK(check_valid_o, 1'b1)
      `CHK(check_byte_bands_0_3_o, 8'h49)
      `CHK(check_byte_bands_4_7_o, 8'h48)
      `CHK(check_byte_bands_8_15_o, (n > 2) ? 8'h47 : 8'h00)
      `CHK(check_byte_bands_16_31_o, (n > 3) ? 8'h46 : 8'h00)
      `CHK(rd_count_o, 6'h36)
      for (k = 0; k < 54; k++)
      begin
        host.read_byte(0, b, g);
        `CHK({g, b}, {1'b1, 8'((k < 2) ? 8'h4B - k : 8'h4B - n - k)})
      end
    end
    $display("checked frames done");
  endtask
  task automatic short_frame;
    subband_limit_i = 6'h14;
    send(6);
    `CHK({check_valid_o, rd_count_o}, {1'b1, 6'h02})
    `CHK(check_byte_bands_16_31_o, 8'h10)
    host.read_byte(0, b, g);
    `CHK({g, b}, 9'h115)
    @(negedge ref_clk_i);
    rd_restart_i = 1'b1;
    @(negedge ref_clk_i);
    rd_restart_i = 1'b0;
    host.read_byte(0, b, g);
    `CHK({g, b}, 9'h115)
    send(5);
    `CHK(check_valid_o, 1'b0)
    frame_locked_flag_i = 1'b0;
    #1 `CHK(buf_valid_o, 1'b0)
    @(negedge ref_clk_i);
    frame_locked_flag_i = 1'b1;
    #1 `CHK(buf_valid_o, 1'b1)
    $display("short frame done");
  endtask
  task automatic midrun_reset;
    @(negedge ref_clk_i);
    rst_b_i = 1'b0;
    #1 `CHK({buf_valid_o, rd_count_o, check_valid_o}, {1'b0, 6'h00, 1'b0})
    `CHK({in_ready_o, rd_valid_o, frame_done_o}, 3'b100)
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    host.read_byte(0, b, g);
    `CHK(g, 1'b0)
    $display("midrun reset done");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    complete_run;
  end
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    `CHK({in_ready_o, buf_valid_o, rd_count_o}, {1'b1, 1'b0, 6'h00})
    rst_b_i = 1'b1;
    frame_locked_flag_i = 1'b1;
    plain_frame;
    checked_frames;
    short_frame;
    midrun_reset;
    complete_run;
  end
endmodule
`default_nettype wire
